// file: hdl/acs_pkg.sv
// Constants for the converter command decoder and scan sequencer
package acs_pkg;
  // Input byte layout
  localparam int CONV_FLAG_BIT = 7;
  localparam int CHAN_HI = 6;
  localparam int CHAN_LO = 3;
  localparam int SCAN_HI = 2;
  localparam int SCAN_LO = 1;
  localparam int TEMP_BIT = 0;
  localparam int CLK_HI = 5;
  localparam int CLK_LO = 4;
  localparam int REF_HI = 3;
  localparam int REF_LO = 2;
  localparam int PAIR_HI = 1;
  localparam int PAIR_LO = 0;
  localparam int AVG_EN_BIT = 4;
  localparam int AVG_CNT_HI = 3;
  localparam int AVG_CNT_LO = 2;
  localparam int REP_HI = 1;
  localparam int REP_LO = 0;
  localparam int RESET_BIT = 3;
  // Power-up values
  localparam logic [7:0] SETUP_RESET = 8'h20;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  // Modes
  localparam logic [1:0] SCAN_LOW_TO_N = 2'h0;
  localparam logic [1:0] SCAN_N_TO_TOP = 2'h1;
  localparam logic [1:0] SCAN_REPEAT = 2'h2;
  localparam logic [1:0] SCAN_ONCE = 2'h3;
  localparam logic [1:0] CLK_PIN_INT = 2'h0;
  localparam logic [1:0] CLK_PIN_EXT = 2'h1;
  localparam logic [1:0] CLK_SER_INT = 2'h2;
  localparam logic [1:0] CLK_SER_EXT = 2'h3;
  localparam logic [1:0] REF_EXT_DIFF = 2'h3;
  localparam logic [1:0] REF_INT_OFF = 2'h0;
  localparam logic [1:0] PAIR_UNI = 2'h2;
  localparam logic [1:0] PAIR_BI = 2'h3;
  // Timing, internal oscillator cycles per step
  localparam int SAMPLE_NS = 3200;
  localparam int TEMP_NS = 8000;
  localparam int WAKE_NS = 40000;
  localparam int CLK_NS = 8;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TEMP_CYC = (TEMP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BYTE_BITS = 8;
  localparam int PAIR_FRAME_BITS = 16;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAKE = 3'b001,
    ST_TEMP = 3'b011,
    ST_PICK = 3'b010,
    ST_CONV = 3'b110,
    ST_DONE = 3'b111
  } acs_state_type;
endpackage

// file: hdl/acs_serial_rx.sv
// Serial input shifter on the link clock, hands whole bytes across by toggle
`timescale 1ns/100ps
module acs_serial_rx (
  // Reset
  input wire logic rst,
  // Link side
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_din,
  // Byte hand-off
  output logic [7:0] byte_data,
  output logic byte_toggle,
  output logic frame_first
);
  import acs_pkg::*;
  logic [2:0] bit_cnt_ff;
  logic [6:0] shift_ff;
  logic first_ff;
  wire [7:0] full_byte = {shift_ff, link_din};

  // Chip select clears the counters, so a frame always starts on a byte edge
  always_ff @(posedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      bit_cnt_ff <= 3'h0;
      shift_ff <= 7'h00;
      first_ff <= 1'b1;
    end else begin
      // MSB first, sampled on rising edge
      shift_ff <= full_byte[6:0]; // RULE23
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (bit_cnt_ff == 3'h7) begin
        first_ff <= 1'b0;
      end
    end
  end

  // Hand-off registers keep their value across frames, so only the system reset clears them
  always_ff @(posedge link_sclk or posedge rst) begin
    if (rst) begin
      byte_data <= 8'h00;
      byte_toggle <= 1'b0;
      frame_first <= 1'b0;
    end else if (!link_cs_n && bit_cnt_ff == 3'h7) begin
      byte_data <= full_byte;
      byte_toggle <= ~byte_toggle;
      frame_first <= first_ff;
    end
  end
endmodule

// file: hdl/acs_top.sv
// Command decoder and scan sequencer of the multichannel converter
`timescale 1ns/100ps
import acs_pkg::*;
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE1: Byte with MSB set is a conversion write: channel, scan mode, temperature.
// RULE2: Four-bit channel field selects input 0 to 15 in binary.
// RULE3: Scan 00 is 0..N, 01 is N..top, 10 repeats N, 11 once.
// RULE4: Ranged scans give one result per channel or pair, plus temperature.
// RULE5: Temperature request gives one measurement, first result of the scan.
// RULE6: Modes 10 and 11 start on register write; 00 and 01 on pin pulse.
// RULE7: Channels used as start pin or negative reference are skipped.
// RULE8: Top pair is ignored if either member is reassigned.
// RULE9: Host names the lower pair channel and only existing channels.
// RULE10: Setup byte holds clock mode, reference mode and pair access fields.
// RULE11: Pair access 10 writes unipolar pairs next, 11 bipolar pairs.
// RULE12: Host sends pair byte right after setup within 16 clocks.
// RULE13: Pair access 00 or 01 leaves pair registers; next byte is fresh.
// RULE14: Pair in both registers runs unipolar.
// RULE15: Unipolar results straight binary, bipolar results two's complement.
// RULE16: Averaging enable bit 4 averages up to 32 samples per result.
// RULE17: Repeat scan result count comes from the two repeat count bits.
// RULE18: Clock mode 11 disables averaging.
// RULE19: Reset bit 1 clears the result store, 0 restores power-up defaults.
// RULE20: Internal scan time is sample x average x results plus temp and wake.
// RULE21: Mode 01 follows start pin hold; mode 11 follows serial clock. The code holds mode 11 samples while chip select stays low.
// RULE22: Power-up is all zeros except setup clock mode 10.
// RULE23: Frame starts with an 8-bit byte MSB first on rising clock.
// RULE24: Mode 10 starts timed scans from a write; 11 disables scanning.
// RULE25: Leading 01 setup, 001 averaging, 0001 reset; low reset bits ignored.
module acs_top #(
  parameter int NUM_CHAN = 16,
  parameter int SAMPLE_CYCLES = acs_pkg::SAMPLE_CYC,
  parameter int TEMP_CYCLES = acs_pkg::TEMP_CYC,
  parameter int WAKE_CYCLES = acs_pkg::WAKE_CYC
) (
  // System
  input wire logic sys_clk,
  input wire logic rst,
  // Serial link
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_din,
  // Conversion start pin
  input wire logic conversion_start_pin_n,
  // Configuration state
  output logic [7:0] setup_config_ff,
  output logic [7:0] averaging_config_ff,
  output logic [7:0] unipolar_pair_enable_ff,
  output logic [7:0] bipolar_pair_enable_ff,
  // Sequencer outputs to the converter core
  output logic busy,
  output logic sample_strobe,
  output logic temp_strobe,
  output logic [3:0] sample_chan,
  output logic sample_is_pair,
  output logic sample_twos_comp,
  output logic [5:0] sample_avg,
  output logic result_clear,
  output logic scan_done
);
  import acs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Link side receiver and crossing
  logic [7:0] rx_byte;
  logic rx_toggle;
  logic rx_first;
  acs_serial_rx u_rx (
    .rst(rst),
    .link_sclk(link_sclk),
    .link_cs_n(link_cs_n),
    .link_din(link_din),
    .byte_data(rx_byte),
    .byte_toggle(rx_toggle),
    .frame_first(rx_first)
  );

  logic tog_s1_ff, tog_s2_ff, tog_s3_ff;
  logic pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic cs_s1_ff, cs_s2_ff;
  // Byte data stands a full byte time after the toggle, so the synced event captures it
  logic [7:0] in_byte_ff;
  logic in_first_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tog_s1_ff <= 1'b0;
      tog_s2_ff <= 1'b0;
      tog_s3_ff <= 1'b0;
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      pin_s3_ff <= 1'b1;
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
    end else begin
      tog_s1_ff <= rx_toggle;
      tog_s2_ff <= tog_s1_ff;
      tog_s3_ff <= tog_s2_ff;
      pin_s1_ff <= conversion_start_pin_n;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      cs_s1_ff <= link_cs_n;
      cs_s2_ff <= cs_s1_ff;
    end
  end
  wire byte_evt = tog_s2_ff ^ tog_s3_ff;
  always_ff @(posedge sys_clk) begin
    if (byte_evt) begin
      in_byte_ff <= rx_byte;
      in_first_ff <= rx_first;
    end
  end
  wire pin_fall = pin_s3_ff & ~pin_s2_ff;
  wire pin_low = ~pin_s2_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Byte decode
  logic pair_pending_ff;
  logic [1:0] pair_target_ff;
  logic [7:0] conversion_request_ff;
  wire [7:0] b = in_byte_ff;
  // A byte may arrive at the decode one cycle after the toggle; delay the event
  logic evt_d_ff;
  wire take_pair = evt_d_ff & pair_pending_ff & ~in_first_ff;
  wire is_conv = evt_d_ff & ~take_pair & b[CONV_FLAG_BIT]; // RULE1
  wire is_setup = evt_d_ff & ~take_pair & (b[7:6] == 2'b01); // RULE25
  wire is_avg = evt_d_ff & ~take_pair & (b[7:5] == 3'b001); // RULE25
  wire is_reset = evt_d_ff & ~take_pair & (b[7:4] == 4'b0001); // RULE25
  wire full_reset = is_reset & ~b[RESET_BIT]; // RULE19
  wire fifo_reset = is_reset & b[RESET_BIT]; // RULE19
  wire [1:0] new_pair = b[PAIR_HI:PAIR_LO];
  wire [1:0] clock_mode = setup_config_ff[CLK_HI:CLK_LO];
  wire [1:0] ref_mode = setup_config_ff[REF_HI:REF_LO];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt_d_ff <= 1'b0;
      setup_config_ff <= SETUP_RESET; // RULE22
      averaging_config_ff <= ZERO_RESET;
      unipolar_pair_enable_ff <= ZERO_RESET;
      bipolar_pair_enable_ff <= ZERO_RESET;
      conversion_request_ff <= ZERO_RESET;
      pair_pending_ff <= 1'b0;
      pair_target_ff <= 2'h0;
      result_clear <= 1'b0;
    end else begin
      evt_d_ff <= byte_evt;
      result_clear <= is_reset;
      if (full_reset) begin
        setup_config_ff <= SETUP_RESET; // RULE19
        averaging_config_ff <= ZERO_RESET;
        unipolar_pair_enable_ff <= ZERO_RESET;
        bipolar_pair_enable_ff <= ZERO_RESET;
        conversion_request_ff <= ZERO_RESET;
        pair_pending_ff <= 1'b0;
      end else begin
        if (is_conv) begin
          conversion_request_ff <= b;
        end
        if (is_avg) begin
          averaging_config_ff <= b;
        end
        if (is_setup) begin
          setup_config_ff <= b; // RULE10
          // Only 10 and 11 arm a following data byte
          pair_pending_ff <= new_pair[1]; // RULE11 RULE13
          pair_target_ff <= new_pair;
        end else if (evt_d_ff) begin
          pair_pending_ff <= 1'b0;
        end
        if (take_pair && pair_target_ff == PAIR_UNI) begin
          unipolar_pair_enable_ff <= b; // RULE11
        end
        if (take_pair && pair_target_ff == PAIR_BI) begin
          bipolar_pair_enable_ff <= b; // RULE11
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel availability
  // Start pin input is the top channel in modes 00/01; negative reference the next in mode 11
  localparam logic [3:0] TOP_CH = 4'(NUM_CHAN - 1);
  localparam logic [3:0] REFN_CH = 4'(NUM_CHAN - 2);
  wire start_taken = ~clock_mode[1];
  wire refn_taken = (ref_mode == REF_EXT_DIFF);

  function automatic logic chan_ok(input logic [3:0] ch, input logic st, input logic rn);
    chan_ok = !((st && ch == TOP_CH) || (rn && ch == REFN_CH)); // RULE7
  endfunction

  // Pair index of a channel, bit 7 is pair 0/1
  function automatic logic pair_bit(input logic [7:0] r, input logic [3:0] ch);
    pair_bit = r[3'(7 - int'(ch[3:1]))];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Scan sequencer
  acs_state_type state_ff, nxt_state;
  logic [3:0] chan_ff, nxt_chan;
  logic [3:0] last_ff;
  logic [5:0] rep_ff;
  logic [31:0] wait_ff;
  logic [5:0] avg_cnt_ff;
  logic st_ff, rn_ff;
  logic [7:0] uni_snap_ff, bi_snap_ff;
  logic [1:0] scan_ff;
  logic [1:0] cmode_ff;

  // A serial start must use the byte being written, the stored copy is one cycle late
  wire [7:0] conv_now = is_conv ? b : conversion_request_ff;
  wire [1:0] req_scan = conv_now[SCAN_HI:SCAN_LO];
  wire [3:0] req_chan = conv_now[CHAN_HI:CHAN_LO]; // RULE2
  wire req_temp = conv_now[TEMP_BIT];
  wire avg_on = averaging_config_ff[AVG_EN_BIT] & (clock_mode != CLK_SER_EXT); // RULE16 RULE18
  wire [1:0] navg_code = averaging_config_ff[AVG_CNT_HI:AVG_CNT_LO];
  // Codes 00..11 give 4, 8, 16, 32 samples
  wire [5:0] n_avg = avg_on ? (6'h04 << navg_code) : 6'h01;
  wire [1:0] nscan = averaging_config_ff[REP_HI:REP_LO];
  wire [5:0] n_rep = 6'h04 << nscan; // RULE17

  // Start source follows clock mode
  wire start_ser = is_conv & (clock_mode == CLK_SER_INT || clock_mode == CLK_SER_EXT); // RULE6 RULE24
  wire start_pin = pin_fall & start_taken; // RULE6
  wire start_req = (state_ff == ST_IDLE) & (start_ser | start_pin);
  wire need_wake = (ref_mode == REF_INT_OFF);

  wire uni_cur = pair_bit(uni_snap_ff, chan_ff);
  wire bi_cur = pair_bit(bi_snap_ff, chan_ff);
  wire cur_pair = uni_cur | bi_cur;
  // Top pair dropped if either member is reassigned
  wire pair_dead = cur_pair & (!chan_ok({chan_ff[3:1], 1'b0}, st_ff, rn_ff) ||
                               !chan_ok({chan_ff[3:1], 1'b1}, st_ff, rn_ff)); // RULE8
  wire cur_ok = cur_pair ? ~pair_dead : chan_ok(chan_ff, st_ff, rn_ff); // RULE7
  wire step_done = (wait_ff == 32'h0);
  // Mode 01 holds each sample while the pin stays low; mode 11 holds it while chip select stays low
  wire ext_hold = (cmode_ff == CLK_PIN_EXT) ? pin_low :
                  (cmode_ff == CLK_SER_EXT) ? ~cs_s2_ff : 1'b0; // RULE21
  wire ranged = (scan_ff == SCAN_LOW_TO_N) || (scan_ff == SCAN_N_TO_TOP);
  wire [3:0] step = cur_pair ? 4'h2 : 4'h1; // RULE4
  wire last_chan = ({1'b0, chan_ff} + {1'b0, step}) > {1'b0, last_ff};
  wire more = ranged ? ~last_chan : (scan_ff == SCAN_REPEAT) ? (rep_ff > 6'h1) : 1'b0;

  always_comb begin
    nxt_state = state_ff;
    nxt_chan = chan_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_req) begin
          nxt_state = need_wake ? ST_WAKE : (req_temp ? ST_TEMP : ST_PICK);
          nxt_chan = (req_scan == SCAN_LOW_TO_N && clock_mode != CLK_SER_EXT) ? 4'h0 : req_chan; // RULE3
        end
      end
      ST_WAKE: begin
        if (step_done) begin
          nxt_state = req_temp ? ST_TEMP : ST_PICK; // RULE5
        end
      end
      ST_TEMP: begin
        if (step_done) begin
          nxt_state = ST_PICK;
        end
      end
      ST_PICK: begin
        if (cur_ok) begin
          nxt_state = ST_CONV;
        end else if (more) begin
          nxt_chan = chan_ff + step;
        end else begin
          nxt_state = ST_DONE;
        end
      end
      ST_CONV: begin
        if (step_done && avg_cnt_ff <= 6'h1 && !ext_hold) begin
          if (more) begin
            nxt_state = ST_PICK;
            nxt_chan = ranged ? chan_ff + step : chan_ff;
          end else begin
            nxt_state = ST_DONE;
          end
        end
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
    if (full_reset) begin
      nxt_state = ST_IDLE;
    end
  end

  // Per-step timing, total time adds up per sample, average and result
  wire [31:0] load_wait =
    (nxt_state == ST_WAKE) ? 32'(WAKE_CYCLES) :
    (nxt_state == ST_TEMP) ? 32'(TEMP_CYCLES) : 32'(SAMPLE_CYCLES); // RULE20
  wire entering = nxt_state != state_ff;
  wire sample_end = (state_ff == ST_CONV) && step_done && !ext_hold;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      chan_ff <= 4'h0;
      last_ff <= 4'h0;
      rep_ff <= 6'h00;
      wait_ff <= 32'h0;
      avg_cnt_ff <= 6'h00;
      st_ff <= 1'b0;
      rn_ff <= 1'b0;
      uni_snap_ff <= 8'h00;
      bi_snap_ff <= 8'h00;
      scan_ff <= 2'h0;
      cmode_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      chan_ff <= nxt_chan;
      if (start_req) begin
        scan_ff <= req_scan;
        cmode_ff <= clock_mode;
        // Mode 11 has no scanning: only one result
        if (clock_mode == CLK_SER_EXT) begin
          scan_ff <= SCAN_ONCE; // RULE24
        end
        last_ff <= (req_scan == SCAN_N_TO_TOP) ? TOP_CH : req_chan; // RULE3
        rep_ff <= n_rep;
        st_ff <= start_taken;
        rn_ff <= refn_taken;
        uni_snap_ff <= unipolar_pair_enable_ff;
        bi_snap_ff <= bipolar_pair_enable_ff;
      end
      if (entering) begin
        wait_ff <= load_wait;
        avg_cnt_ff <= n_avg;
      end else if (sample_end && avg_cnt_ff > 6'h1) begin
        wait_ff <= load_wait;
        avg_cnt_ff <= avg_cnt_ff - 6'h1;
      end else if (!step_done) begin
        wait_ff <= wait_ff - 32'h1;
      end
      if (sample_end && avg_cnt_ff <= 6'h1 && scan_ff == SCAN_REPEAT) begin
        rep_ff <= rep_ff - 6'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs to the converter core
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sample_strobe <= 1'b0;
      temp_strobe <= 1'b0;
      sample_chan <= 4'h0;
      sample_is_pair <= 1'b0;
      sample_twos_comp <= 1'b0;
      sample_avg <= 6'h00;
      scan_done <= 1'b0;
    end else begin
      sample_strobe <= (state_ff == ST_PICK) && (nxt_state == ST_CONV);
      temp_strobe <= (state_ff != ST_TEMP) && (nxt_state == ST_TEMP); // RULE5
      scan_done <= (state_ff == ST_DONE);
      if (state_ff == ST_PICK && nxt_state == ST_CONV) begin
        sample_chan <= cur_pair ? {chan_ff[3:1], 1'b0} : chan_ff;
        sample_is_pair <= cur_pair;
        // Unipolar wins when both are set
        sample_twos_comp <= bi_cur & ~uni_cur; // RULE14 RULE15
        sample_avg <= n_avg;
      end
    end
  end
  assign busy = (state_ff != ST_IDLE);
endmodule

// file: verif/acs_top_sva.sv
// Checker for the command decoder and scan sequencer outputs
`timescale 1ns/100ps
module acs_top_sva #(
  parameter int NUM_CHAN = 16
) (
  // Clocks and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_sclk,
  // Inputs
  input wire logic link_cs_n,
  input wire logic link_din,
  input wire logic conversion_start_pin_n,
  // Observed outputs
  input wire logic [7:0] setup_config_ff,
  input wire logic [7:0] averaging_config_ff,
  input wire logic [7:0] unipolar_pair_enable_ff,
  input wire logic [7:0] bipolar_pair_enable_ff,
  input wire logic busy,
  input wire logic sample_strobe,
  input wire logic temp_strobe,
  input wire logic [3:0] sample_chan,
  input wire logic sample_is_pair,
  input wire logic sample_twos_comp,
  input wire logic [5:0] sample_avg,
  input wire logic result_clear,
  input wire logic scan_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic seen_sample_ff;
  logic nxt_seen_sample;
  // Remembers a sample inside the current scan so a late temperature is caught
  assign nxt_seen_sample = busy && (seen_sample_ff || sample_strobe);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) seen_sample_ff <= 1'b0;
    else seen_sample_ff <= nxt_seen_sample;
  end
  //////////////////////////////////////////////////////////////////////////////
  power_up_a: assert property ($fell(rst) |-> setup_config_ff == 8'h20 && unipolar_pair_enable_ff == 8'h00
    && !busy) else $error("power-up values wrong");
  temp_first_a: assert property (temp_strobe |-> !seen_sample_ff) else $error("temperature after a sample");
  strobe_busy_a: assert property (sample_strobe || temp_strobe |-> busy) else $error("strobe while idle");
  sample_gap_a: assert property (sample_strobe |=> !sample_strobe [*3]) else $error("samples too close");
  done_idle_a: assert property (scan_done |-> ##[0:2] !busy) else $error("busy after scan end");
  twos_pair_a: assert property (sample_twos_comp && sample_strobe |-> sample_is_pair)
    else $error("two's complement on single channel");
  pair_lower_a: assert property (sample_strobe && sample_is_pair |-> !sample_chan[0]) else $error("odd pair channel");
  avg_limit_a: assert property (sample_strobe |-> sample_avg <= 6'h20 && sample_avg != 6'h00)
    else $error("average count out of range");
  pin_skip_a: assert property (sample_strobe && !setup_config_ff[5] |-> sample_chan != 4'(NUM_CHAN - 1))
    else $error("start pin channel converted");
  ref_skip_a: assert property (sample_strobe && setup_config_ff[3:2] == 2'h3 |-> sample_chan != 4'(NUM_CHAN - 2))
    else $error("negative reference channel converted");
  clear_pulse_a: assert property (result_clear |=> !result_clear) else $error("result clear too long");
endmodule
bind acs_top acs_top_sva #(.NUM_CHAN(NUM_CHAN)) i_acs_top_sva (.sys_clk(sys_clk), .rst(rst),
  .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_din(link_din),
  .conversion_start_pin_n(conversion_start_pin_n), .setup_config_ff(setup_config_ff),
  .averaging_config_ff(averaging_config_ff), .unipolar_pair_enable_ff(unipolar_pair_enable_ff),
  .bipolar_pair_enable_ff(bipolar_pair_enable_ff), .busy(busy), .sample_strobe(sample_strobe),
  .temp_strobe(temp_strobe), .sample_chan(sample_chan), .sample_is_pair(sample_is_pair),
  .sample_twos_comp(sample_twos_comp), .sample_avg(sample_avg), .result_clear(result_clear),
  .scan_done(scan_done));

// file: verif/acs_serial_master.sv
// Serial host model that sends frames on the 3-wire link
`timescale 1ns/100ps
module acs_serial_master (
  // Link
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_din
);
  // Clock rests low between frames and only runs inside them
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_din = 1'b1;
  end
  task automatic send_frame(input logic [15:0] bits, input int n);
    #7 link_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      link_din = bits[n - 1 - i];
      #24 link_sclk = 1'b1;
      #24 link_sclk = 1'b0;
    end
    // Pair bytes stay in one frame of 16 clocks
    #24 link_cs_n = 1'b1;
    // Released data line must not keep the last bit
    link_din = ~link_din;
  endtask
endmodule

// file: verif/acs_top_bench.sv
// Self-checking bench for the command decoder and scan sequencer
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module acs_top_bench;
  import acs_pkg::*;
  logic sys_clk, rst, link_sclk, link_cs_n, link_din, conversion_start_pin_n;
  logic [7:0] setup_config_ff, averaging_config_ff, unipolar_pair_enable_ff, bipolar_pair_enable_ff;
  logic busy, sample_strobe, temp_strobe, sample_is_pair, sample_twos_comp, result_clear, scan_done;
  logic [3:0] sample_chan, last_chan;
  logic [5:0] sample_avg, last_avg;
  int errors, check_count, n_samp, n_temp, n_done, n_clr, n_pair, n_twos, n_busy, cyc;
  logic [3:0] chans [3] = '{4'h0, 4'h5, 4'hf};
  acs_top #(.NUM_CHAN(16), .SAMPLE_CYCLES(4), .TEMP_CYCLES(8), .WAKE_CYCLES(16)) i_acs_top (
    .sys_clk(sys_clk), .rst(rst), .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_din(link_din),
    .conversion_start_pin_n(conversion_start_pin_n), .setup_config_ff(setup_config_ff),
    .averaging_config_ff(averaging_config_ff), .unipolar_pair_enable_ff(unipolar_pair_enable_ff),
    .bipolar_pair_enable_ff(bipolar_pair_enable_ff), .busy(busy), .sample_strobe(sample_strobe),
    .temp_strobe(temp_strobe), .sample_chan(sample_chan), .sample_is_pair(sample_is_pair),
    .sample_twos_comp(sample_twos_comp), .sample_avg(sample_avg), .result_clear(result_clear),
    .scan_done(scan_done));
  acs_serial_master i_acs_serial_master (.link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_din(link_din));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (sample_strobe === 1'b1) begin
      n_samp++;
      last_chan = sample_chan;
      last_avg = sample_avg;
      if (sample_is_pair === 1'b1) n_pair++;
      if (sample_twos_comp === 1'b1) n_twos++;
    end
    if (temp_strobe === 1'b1) n_temp++;
    if (scan_done === 1'b1) n_done++;
    if (result_clear === 1'b1) n_clr++;
    if (busy === 1'b1) n_busy++;
    cyc++;
    if (cyc == 60000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic clr();
    n_samp = 0; n_temp = 0; n_done = 0; n_clr = 0; n_pair = 0; n_twos = 0; n_busy = 0;
  endtask
  // Registers settle a few system clocks after the frame
  task automatic send(input logic [15:0] v, input int n);
    i_acs_serial_master.send_frame(v, n);
    repeat (10) @(negedge sys_clk);
  endtask
  task automatic scan(input int exp_s, input int exp_t, input logic [3:0] exp_last);
    int k;
    k = 0;
    while (n_done == 0 && k < 3000) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (3) @(negedge sys_clk);
    `CHK(n_done, 1)
    `CHK(n_samp, exp_s)
    `CHK(n_temp, exp_t)
    `CHK(last_chan, exp_last)
  endtask
  initial begin
    errors = 0; check_count = 0; cyc = 0; clr();
    rst = 1'b1;
    conversion_start_pin_n = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK(setup_config_ff, 8'h20)
    `CHK(averaging_config_ff, 8'h00)
    `CHK(bipolar_pair_enable_ff, 8'h00)
    $display("test power_up done");
    send({8'h62, 8'ha5}, 16);
    `CHK(unipolar_pair_enable_ff, 8'ha5)
    `CHK(setup_config_ff[5:0], 6'h22)
    send({8'h63, 8'h5a}, 16);
    `CHK(bipolar_pair_enable_ff, 8'h5a)
    send({8'h61, 8'h3d}, 16);
    `CHK(unipolar_pair_enable_ff, 8'ha5)
    `CHK(averaging_config_ff[4:0], 5'h1d)
    clr(); send(16'h001f, 8);
    `CHK(n_clr, 1)
    `CHK(unipolar_pair_enable_ff, 8'ha5)
    clr(); send(16'h0017, 8);
    `CHK(n_clr, 1)
    `CHK(setup_config_ff, 8'h20)
    `CHK(unipolar_pair_enable_ff, 8'h00)
    `CHK(averaging_config_ff, 8'h00)
    $display("test registers done");
    foreach (chans[i]) begin
      clr(); send({8'h00, 1'b1, chans[i], 3'b110}, 8);
      scan(1, 0, chans[i]);
    end
    clr(); send(16'h0099, 8);
    scan(4, 1, 4'h3);
    // Wake 16, temperature 8 and four samples of 4 cycles at the least
    `CHK(n_busy >= 40, 1'b1)
    clr(); send(16'h00e2, 8);
    scan(4, 0, 4'hf);
    $display("test scans done");
    send({8'h62, 8'h80}, 16);
    send({8'h63, 8'h80}, 16);
    clr(); send(16'h0098, 8);
    scan(3, 0, 4'h3);
    `CHK(n_pair, 1)
    `CHK(n_twos, 0)
    send(16'h0017, 8);
    send({8'h63, 8'h80}, 16);
    clr(); send(16'h0088, 8);
    scan(1, 0, 4'h0);
    `CHK(n_twos, 1)
    $display("test pairs done");
    send(16'h0030, 8);
    clr(); send(16'h0094, 8);
    scan(4, 0, 4'h2);
    `CHK(last_avg, 6'h04)
    $display("test repeat done");
    send(16'h0017, 8);
    send({8'h4e, 8'h01}, 16);
    clr(); send(16'h00e2, 8);
    repeat (200) @(negedge sys_clk);
    `CHK(n_done, 0)
    conversion_start_pin_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    conversion_start_pin_n = 1'b1;
    // Pin and negative reference channels drop out, and the top pair with them
    scan(2, 0, 4'hd);
    $display("test start_pin done");
    send(16'h0017, 8);
    send(16'h0030, 8);
    send(16'h0070, 8);
    clr(); send(16'h00e2, 8);
    scan(1, 0, 4'hc);
    `CHK(last_avg, 6'h01)
    $display("test serial_clock done");
    end_sim();
  end
endmodule
